// *** hw/supply_supervisor_watchdog.sv ***
// Supervisory reset generator: supply, manual reset, watchdog, warnings.
// Assumes analog comparators arrive as async digital levels on clk.
//
// Contract
// - Reset held during supply low conditions
// - Manual reset low asserts reset output
// - Reset pulses hold time, stays while held
// - Extra hold time after cause releases
// - Active-high output is exact inverse
// - Power-fail output follows its comparator
// - Low-supply warning precedes reset threshold
// - Watchdog restarts on either kick edge
// - Hold and timeout fixed at build
// - Hold time chosen from four values
`timescale 1ns/100ps
module supply_supervisor_watchdog #(
  parameter int unsigned HOLD_SEL = 2,
  parameter int unsigned HOLD_CYCLES = supervisor_pkg::hold_cycles(HOLD_SEL),
  parameter int unsigned WDOG_CYCLES = supervisor_pkg::WDOG_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Comparator results, high when the level is above its threshold
  input wire logic supply_ok_in,
  input wire logic supply_above_low_in,
  input wire logic power_fail_sense_in,
  // Pins from the processor
  input wire logic manual_reset_n,
  input wire logic watchdog_kick_in,
  // Outputs
  output logic reset_out_n,
  output logic reset_out,
  output logic power_fail_warn_n,
  output logic low_supply_warn_n
);
  localparam int unsigned CW = supervisor_pkg::CNT_W;
  localparam logic [CW-1:0] HOLD_LAST = CW'(HOLD_CYCLES - 1);
  localparam logic [CW-1:0] WDOG_LAST = CW'(WDOG_CYCLES - 1);
  localparam logic [CW-1:0] CNT_ZERO = '0;
  localparam logic [CW-1:0] CNT_FULL = '1;
  localparam logic [CW-1:0] HOLD_FULL = CW'(HOLD_CYCLES);

  typedef enum logic [2:0] {
    ST_HELD = 3'h1,
    ST_HOLD = 3'h2,
    ST_RUN = 3'h4
  } state_t;

  // Synchronise every outside level reset state means bad
  sync_if #(.W(5)) lv ();
  assign lv.raw = {supply_ok_in, supply_above_low_in, power_fail_sense_in,
                   manual_reset_n, watchdog_kick_in};
  level_sync #(.W(5), .RST_VAL(5'h00)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .s(lv)
  );
  logic supply_ok, above_low, pf_ok, mr_n, kick;
  assign {supply_ok, above_low, pf_ok, mr_n, kick} = lv.synced;

  // A held cause is supply below threshold or manual reset low
  logic cause;
  assign cause = !supply_ok || !mr_n;

  state_t state_q, state_d;
  logic [CW-1:0] hold_q, hold_d, wd_q, wd_d;
  logic kick_q, kick_d, rst_n_q, rst_n_d, rst_q, rst_d;
  logic pfw_q, pfw_d, llw_q, llw_d;
  logic wd_fire;

  // Watchdog: restart on any kick edge, cleared while reset asserted
  always_comb begin
    kick_d = kick;
    wd_fire = 1'b0;
    if (state_q != ST_RUN || kick != kick_q) begin
      wd_d = CNT_ZERO;
    end else if (wd_q == WDOG_LAST) begin
      wd_d = CNT_ZERO;
      wd_fire = 1'b1;
    end else begin
      wd_d = wd_q + 1'b1;
    end
  end

  // Reset sequencer; hold counter length is fixed at build time
  always_comb begin
    state_d = state_q;
    hold_d = hold_q;
    unique case (state_q)
      ST_HELD: begin
        hold_d = CNT_ZERO;
        if (!cause) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (cause) begin
          state_d = ST_HELD;
        end else if (hold_q == HOLD_LAST) begin
          state_d = ST_RUN;
        end else begin
          hold_d = hold_q + 1'b1;
        end
      end
      ST_RUN: begin
        if (cause) begin
          state_d = ST_HELD;
        end else if (wd_fire) begin
          state_d = ST_HOLD; // Timeout gives one hold-time pulse
          hold_d = CNT_ZERO;
        end
      end
      default: begin
        state_d = ST_HELD;
        hold_d = CNT_ZERO;
      end
    endcase
  end

  // Registered outputs; warnings ignore the reset sequencer
  always_comb begin
    rst_n_d = (state_d == ST_RUN);
    rst_d = !(state_d == ST_RUN);
    pfw_d = pf_ok;
    llw_d = above_low && supply_ok;
  end

  // Starting in ST_HELD covers power-up
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ST_HELD;
      hold_q <= '0;
      wd_q <= '0;
      kick_q <= 1'b0;
      rst_n_q <= 1'b0;
      rst_q <= 1'b1;
      pfw_q <= 1'b0;
      llw_q <= 1'b0;
    end else begin
      state_q <= state_d;
      hold_q <= hold_d;
      wd_q <= wd_d;
      kick_q <= kick_d;
      rst_n_q <= rst_n_d;
      rst_q <= rst_d;
      pfw_q <= pfw_d;
      llw_q <= llw_d;
    end
  end

  assign reset_out_n = rst_n_q;
  assign reset_out = rst_q;
  assign power_fail_warn_n = pfw_q;
  assign low_supply_warn_n = llw_q;

  // Check helper: edges with reset low although no cause is present
  logic [CW-1:0] quiet_lo_q, quiet_lo_d;

  always_comb begin
    if (reset_out_n || cause) begin
      quiet_lo_d = CNT_ZERO;
    end else if (quiet_lo_q == CNT_FULL) begin
      quiet_lo_d = quiet_lo_q; // Saturate so a long hold never wraps
    end else begin
      quiet_lo_d = quiet_lo_q + 1'b1;
    end
  end

  // Registered only; it feeds the checks and nothing else
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      quiet_lo_q <= CNT_ZERO;
    end else begin
      quiet_lo_q <= quiet_lo_d;
    end
  end

  // Checks
  a_reset_inverse: assert property (@(posedge clk) disable iff (sys_rst)
    reset_out == !reset_out_n)
    else $error("active-high reset not inverse of active-low");
  a_cause_holds_reset: assert property (@(posedge clk) disable iff (sys_rst)
    cause |=> !reset_out_n)
    else $error("reset released while a cause is present");
  a_mr_asserts: assert property (@(posedge clk) disable iff (sys_rst)
    !mr_n |=> !reset_out_n)
    else $error("manual reset did not assert reset");
  a_release_waits: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(cause) |-> !reset_out_n [*2])
    else $error("reset released too soon after cause");
  a_hold_count_bound: assert property (@(posedge clk) disable iff (sys_rst)
    hold_q <= HOLD_LAST)
    else $error("hold counter beyond hold time");
  a_hold_then_release: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == ST_HOLD && hold_q == HOLD_LAST && !cause)
      |=> reset_out_n)
    else $error("reset not released at end of hold");
  a_pf_follows: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 power_fail_warn_n == $past(pf_ok))
    else $error("power-fail output not following comparator");
  a_low_before_rst: assert property (@(posedge clk) disable iff (sys_rst)
    !supply_ok |=> !low_supply_warn_n)
    else $error("low-supply warning not asserted below reset level");
  a_wdog_fires: assert property (@(posedge clk) disable iff (sys_rst)
    wd_fire |=> !reset_out_n)
    else $error("watchdog timeout did not assert reset");
  a_wdog_cleared: assert property (@(posedge clk) disable iff (sys_rst)
    state_q != ST_RUN |=> wd_q == CNT_ZERO)
    else $error("watchdog counter running during reset");
  a_hold_full_time: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(reset_out_n) |-> quiet_lo_q >= HOLD_FULL)
    else $error("reset released before a full hold time");
  a_low_warn_early: assert property (@(posedge clk) disable iff (sys_rst)
    !above_low |=> !low_supply_warn_n)
    else $error("low-supply warning missing above reset level");
  a_kick_restarts: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == ST_RUN && kick != kick_q) |=> wd_q == CNT_ZERO)
    else $error("kick edge did not restart the watchdog");
  c_low_warn: cover property (@(posedge clk) $fell(low_supply_warn_n));
  c_wdog_reset: cover property (@(posedge clk) wd_fire);
  c_mr_press: cover property (@(posedge clk) $fell(mr_n));
  c_release: cover property (@(posedge clk) $rose(reset_out_n));
  c_brownout: cover property (@(posedge clk) reset_out_n && !supply_ok);
endmodule // supply_supervisor_watchdog

// *** hw/supervisor_pkg.sv ***
// Package for the supply supervisor and watchdog block.
// Assumes a 20 MHz system clock; all times become cycle counts here.
package supervisor_pkg;
  // Clock period in picoseconds (20 MHz)
  localparam int unsigned CLK_PERIOD_PS = 50000;
  // Nominal reset hold times, in microseconds
  localparam int unsigned HOLD_SEL0_US = 1400;
  localparam int unsigned HOLD_SEL1_US = 28000;
  localparam int unsigned HOLD_SEL2_US = 200000;
  localparam int unsigned HOLD_SEL3_US = 1600000;
  // Default watchdog timeout in microseconds
  localparam int unsigned WDOG_TIMEOUT_US = 1600000;
  localparam int unsigned CNT_W = 26;
  // Cycles per time, rounded up so that a least time is never short
  function automatic int unsigned us_to_cycles(input int unsigned us);
    longint unsigned ps;
    ps = longint'(us) * 64'd1000000;
    return 32'((ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  endfunction
  // Pick the hold time by build-time selector 0..3
  function automatic int unsigned hold_cycles(input int unsigned sel);
    int unsigned us;
    us = HOLD_SEL0_US;
    case (sel)
      1: us = HOLD_SEL1_US;
      2: us = HOLD_SEL2_US;
      3: us = HOLD_SEL3_US;
      default: us = HOLD_SEL0_US;
    endcase
    return us_to_cycles(us);
  endfunction
  localparam int unsigned WDOG_CYCLES = us_to_cycles(WDOG_TIMEOUT_US);
endpackage

// *** hw/sync_if.sv ***
// Interface carrying raw and synchronised comparator and processor pin levels.
// Assumes both modports sit in the clk domain.
`timescale 1ns/100ps
interface sync_if #(parameter int W = 5);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport syncer (input raw, output synced);
  modport user (output raw, input synced);
endinterface // sync_if

// *** hw/level_sync.sv ***
// Two-flop synchroniser for a vector of unrelated levels.
// Assumes inputs are slow levels; each bit settles on its own.
`timescale 1ns/100ps
module level_sync #(
  parameter int W = 5,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Levels
  sync_if.syncer s
);
  logic [W-1:0] meta_q, meta_d, sync_q, sync_d;

  // First stage feeds only the second stage
  always_comb begin
    meta_d = s.raw;
    sync_d = meta_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign s.synced = sync_q;
endmodule // level_sync

// *** verif/cpu_kicker.sv ***
// Model of the supervised processor toggling the watchdog line.
// Assumes the block clock; the bench enables or stops the kicking.
`timescale 1ns/100ps
module cpu_kicker #(
  parameter int PERIOD = 30
) (
  // Clock
  input wire logic clk,
  // Control from the bench
  input wire logic kick_en,
  // Kick line to the supervisor
  output logic kick
);
  int cnt = 0;
  logic kick_q = 1'b0;
  // One toggle per period, so same-direction edges are twice as far apart
  always @(posedge clk) begin
    if (kick_en) begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      if (cnt == PERIOD - 1) kick_q <= ~kick_q;
    end
  end
  // Line stands still while kicking is stopped
  assign kick = kick_q;
endmodule // cpu_kicker

// *** verif/testbench.sv ***
// Self-checking bench for the supply supervisor and watchdog.
// Assumes short hold and timeout counts given as parameters.
`timescale 1ns/100ps
module testbench;
  localparam int HOLD = 20;
  localparam int WDOG = 50;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic supply_ok_in = 1'b1;
  logic supply_above_low_in = 1'b1;
  logic power_fail_sense_in = 1'b1;
  logic manual_reset_n = 1'b1;
  logic kick_en = 1'b0;
  logic watchdog_kick_in;
  logic reset_out_n;
  logic reset_out;
  logic power_fail_warn_n;
  logic low_supply_warn_n;
  int n_errors = 0;
  int total_checks = 0;
  int n;
  // Clock at 20 MHz
  initial forever #25 clk = ~clk;
  supply_supervisor_watchdog #(.HOLD_CYCLES(HOLD), .WDOG_CYCLES(WDOG)) uut (
    .clk(clk), .sys_rst(sys_rst), .supply_ok_in(supply_ok_in),
    .supply_above_low_in(supply_above_low_in),
    .power_fail_sense_in(power_fail_sense_in),
    .manual_reset_n(manual_reset_n), .watchdog_kick_in(watchdog_kick_in),
    .reset_out_n(reset_out_n), .reset_out(reset_out),
    .power_fail_warn_n(power_fail_warn_n),
    .low_supply_warn_n(low_supply_warn_n));
  cpu_kicker #(.PERIOD(30)) kicker (
    .clk(clk), .kick_en(kick_en), .kick(watchdog_kick_in));
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // Outputs are sampled on the falling edge, well clear of updates
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  // Counts cycles until reset lets go, bounded against a hang
  task automatic wait_rel(output int cnt);
    cnt = 0;
    while (reset_out_n !== 1'b1 && cnt < 400) begin
      @(negedge clk);
      cnt++;
    end
  endtask
  task automatic t_power_up();
    cyc(1);
    check("rst during reset", reset_out_n, 0);
    @(posedge clk);
    sys_rst <= 1'b0;
    kick_en <= 1'b1;
    wait_rel(n);
    check("power up hold", n >= HOLD && n <= HOLD + 6, 1);
    check("inverse", reset_out, 0);
  endtask
  task automatic t_manual();
    @(posedge clk);
    manual_reset_n <= 1'b0;
    cyc(4);
    check("mr low", reset_out_n, 0);
    check("mr inverse", reset_out, 1);
    cyc(30);
    check("mr still low", reset_out_n, 0);
    @(posedge clk);
    manual_reset_n <= 1'b1;
    wait_rel(n);
    check("mr hold", n >= HOLD && n <= HOLD + 4, 1);
  endtask
  task automatic t_brownout();
    @(posedge clk);
    supply_above_low_in <= 1'b0;
    cyc(4);
    check("low warn", low_supply_warn_n, 0);
    check("no rst yet", reset_out_n, 1);
    @(posedge clk);
    supply_ok_in <= 1'b0;
    cyc(4);
    check("brownout rst", reset_out_n, 0);
    @(posedge clk);
    supply_ok_in <= 1'b1;
    supply_above_low_in <= 1'b1;
    wait_rel(n);
    check("supply hold", n >= HOLD && n <= HOLD + 4, 1);
    check("low warn off", low_supply_warn_n, 1);
  endtask
  task automatic t_pfail();
    @(posedge clk);
    power_fail_sense_in <= 1'b0;
    cyc(4);
    check("pf warn", power_fail_warn_n, 0);
    check("pf no rst", reset_out_n, 1);
    @(posedge clk);
    power_fail_sense_in <= 1'b1;
    cyc(4);
    check("pf warn off", power_fail_warn_n, 1);
  endtask
  task automatic t_watchdog();
    cyc(200);
    check("kicks keep out", reset_out_n, 1);
    @(posedge clk);
    kick_en <= 1'b0;
    n = 0;
    while (reset_out_n !== 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check("wd fires", n >= WDOG - 30 && n <= WDOG + 5, 1);
    wait_rel(n);
    check("wd pulse", n >= HOLD && n <= HOLD + 2, 1);
    @(posedge clk);
    kick_en <= 1'b1;
  endtask
  // Kicks stop during a manual reset; the count must start afresh after it
  task automatic t_wd_restart();
    @(posedge clk);
    kick_en <= 1'b0;
    manual_reset_n <= 1'b0;
    cyc(40);
    @(posedge clk);
    manual_reset_n <= 1'b1;
    wait_rel(n);
    check("wd restart rel", n, HOLD + 4);
    n = 0;
    while (reset_out_n !== 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check("wd exact timeout", n, WDOG);
    wait_rel(n);
    check("wd exact pulse", n, HOLD);
  endtask
  // Build-time hold choices 1.4, 28, 200 and 1600 ms at 50 ns per cycle
  task automatic t_hold_table();
    check("hold 0", supervisor_pkg::hold_cycles(0), 32'h6D60);
    check("hold 1", supervisor_pkg::hold_cycles(1), 32'h88B80);
    check("hold 2", supervisor_pkg::hold_cycles(2), 32'h3D0900);
    check("hold 3", supervisor_pkg::hold_cycles(3), 32'h1E84800);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    t_power_up();
    t_manual();
    t_brownout();
    t_pfail();
    t_watchdog();
    t_wd_restart();
    t_hold_table();
    final_report();
  end
  // Watchdog on the run; the sequence needs about 530 cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    final_report();
  end
endmodule // testbench
